//--- common/timer_irq_pkg.sv
`default_nettype none
package timer_irq_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_FLAGS = 8'h0b;
	localparam logic [7:0] IDX_MASK = 8'h0c;
	localparam logic [7:0] IDX_CTRL = 8'h0d;
	localparam logic [7:0] IDX_SYNC = 8'h0e;
	localparam logic [7:0] IDX_CMP_A = 8'h10;
	localparam logic [7:0] IDX_CMP_B = 8'h11;
	localparam int ADDR_W = 8;
	// flag and mask bit positions
	localparam int BIT_CAP = 5;
	localparam int BIT_CMP_B = 2;
	localparam int BIT_CMP_A = 1;
	localparam int BIT_OVF = 0;
	localparam logic [7:0] FLAG_MASK = 8'h27;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;
	// sync register
	localparam int BIT_SYNC_HOLD = 7;
	localparam int BIT_PSR = 0;
	// control register fields
	localparam int CS1_LSB = 0;
	localparam int CS0_LSB = 3;
	localparam int WGM_LSB = 6;
	localparam int BIT_CAP_EDGE = 10;
	localparam logic [10:0] CTRL_RST = 11'h000;
	// prescaler tap widths: divide by 8, 64, 256, 1024
	localparam int PRE_W = 10;
	localparam int TAP8_W = 3;
	localparam int TAP64_W = 6;
	localparam int TAP256_W = 8;
	localparam int TAP1024_W = 10;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ADDR_W-1:0] araddr;
		logic rready;
	} axil_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axil_rsp_t;

	// events from the counter core of timer 1, one-cycle pulses
	typedef struct packed {
		logic [15:0] count_value;
		logic at_top;
		logic at_bottom;
		logic at_max;
	} core_evt_t;
endpackage : timer_irq_pkg
`default_nettype wire

//--- hdl/timer_irq_flags_and_prescaler.sv
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module timer_irq_flags_and_prescaler (
	input wire logic aclk,
	input wire logic aresetn,
	input wire timer_irq_pkg::axil_req_t axil_req,
	output timer_irq_pkg::axil_rsp_t axil_rsp,
	input wire timer_irq_pkg::core_evt_t core_evt,
	input wire logic global_irq_en,
	input wire logic [3:0] vector_ack,
	input wire logic capture_input_pin,
	input wire logic [1:0] ext_count_pin,
	output logic [1:0] timer_tick,
	output logic [3:0] irq_req,
	output logic [3:0] waveform_mode,
	output logic [15:0] compare_a_reg,
	output logic [15:0] compare_b_reg
);
	import timer_irq_pkg::*;

	typedef struct packed {
		axil_rsp_t rsp;
		logic [7:0] flags;
		logic [7:0] mask;
		logic [10:0] ctrl;
		logic sync_hold;
		logic psr;
		logic [15:0] cmp_a;
		logic [15:0] cmp_b;
		logic [PRE_W-1:0] pre_cnt;
		logic [1:0] mpend;
		logic [1:0] tick;
		logic [3:0] irq;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	////////////////////////////////////////////////////////////////////////
	logic [1:0] rise;
	logic [1:0] fall;
	logic cap_rise;
	logic cap_fall;
	logic [1:0][2:0] sel;
	wire logic [1:0] tick_now;
	logic cap_edge;
	logic cap_is_top;
	logic ovf_evt;
	logic [7:0] set_v;
	logic [7:0] clr_v;
	logic [7:0] flags_n;
	logic wr_fire;
	logic rd_fire;
	logic [7:0] widx;
	logic [7:0] ridx;
	logic [31:0] rd_val;
	logic rd_ok;
	logic wr_ok;
	logic [3:0] wgm;

	assign wgm = st_r.ctrl[WGM_LSB +: 4];
	assign sel = {st_r.ctrl[CS1_LSB +: 3], st_r.ctrl[CS0_LSB +: 3]};

	////////////////////////////////////////////////////////////////////////
	// pins cross into the clock domain here; bit 1 is timer 1
	pin_edge_sync #(
		.W(2)
	) ext_sync_inst (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(ext_count_pin),
		.rise(rise),
		.fall(fall)
	);

	pin_edge_sync #(
		.W(1)
	) cap_sync_inst (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(capture_input_pin),
		.rise(cap_rise),
		.fall(cap_fall)
	);

	// one source select per timer, both fed by the shared prescaler
	for (genvar t = 0; t < 2; t++) begin : g_src
		tick_select #(
			.PW(PRE_W)
		) tick_select_inst (
			.sel(sel[t]),
			.pre_cnt(st_r.pre_cnt),
			.psr(st_r.psr),
			.rise(rise[t]),
			.fall(fall[t]),
			.tick(tick_now[t])
		);
	end

	always_comb begin
		st_nxt = st_r;

		// prescaler never looks at clock select; only its reset stops it
		if (st_r.psr) begin
			st_nxt.pre_cnt = '0;
		end else begin
			st_nxt.pre_cnt = st_r.pre_cnt + 1'b1;
		end

		// registered tick lands three clocks after the pin edge
		st_nxt.tick = tick_now;

		////////////////////////////////////////////////////////////////////
		// flag sources
		set_v = '0;
		cap_is_top = (wgm == 4'h8) || (wgm == 4'ha) || (wgm == 4'hc) || (wgm == 4'he);
		if (st_r.ctrl[BIT_CAP_EDGE]) begin
			cap_edge = cap_rise;
		end else begin
			cap_edge = cap_fall;
		end
		// pin is disconnected while capture_reg is the top value
		if (cap_is_top) begin
			set_v[BIT_CAP] = core_evt.at_top;
		end else begin
			set_v[BIT_CAP] = cap_edge;
		end

		// match seen on one timer tick, flag raised on the next;
		// only a real match sets it, never a forced strobe
		if (st_r.tick[1]) begin
			st_nxt.mpend[0] = (core_evt.count_value == st_r.cmp_a);
			st_nxt.mpend[1] = (core_evt.count_value == st_r.cmp_b);
			set_v[BIT_CMP_A] = st_r.mpend[0];
			set_v[BIT_CMP_B] = st_r.mpend[1];
		end

		case (wgm)
			4'h0, 4'h4, 4'hc: ovf_evt = core_evt.at_max;
			4'h5, 4'h6, 4'h7, 4'he, 4'hf: ovf_evt = core_evt.at_top;
			4'hd: ovf_evt = 1'b0;
			default: ovf_evt = core_evt.at_bottom;
		endcase
		set_v[BIT_OVF] = ovf_evt;

		////////////////////////////////////////////////////////////////////
		// axi4-lite: both write channels taken in the same cycle
		widx = {2'b00, axil_req.awaddr[ADDR_W-1:2]};
		ridx = {2'b00, axil_req.araddr[ADDR_W-1:2]};
		wr_fire = st_r.rsp.awready & axil_req.awvalid & axil_req.wvalid;
		rd_fire = st_r.rsp.arready & axil_req.arvalid;
		st_nxt.rsp.awready = 1'b0;
		st_nxt.rsp.wready = 1'b0;
		st_nxt.rsp.arready = 1'b0;
		if (axil_req.awvalid && axil_req.wvalid && !st_r.rsp.bvalid && !st_r.rsp.awready) begin
			st_nxt.rsp.awready = 1'b1;
			st_nxt.rsp.wready = 1'b1;
		end
		if (axil_req.arvalid && !st_r.rsp.rvalid && !st_r.rsp.arready) begin
			st_nxt.rsp.arready = 1'b1;
		end
		if (st_r.rsp.bvalid && axil_req.bready) begin
			st_nxt.rsp.bvalid = 1'b0;
		end
		if (st_r.rsp.rvalid && axil_req.rready) begin
			st_nxt.rsp.rvalid = 1'b0;
		end

		// acks follow the request order: capture, compare B, compare A, overflow
		clr_v = {4'h0, 4'h0};
		clr_v[BIT_CAP] = vector_ack[3];
		clr_v[BIT_CMP_B] = vector_ack[2];
		clr_v[BIT_CMP_A] = vector_ack[1];
		clr_v[BIT_OVF] = vector_ack[0];

		// hardware clears the reset bit unless the hold keeps it
		if (!st_r.sync_hold) begin
			st_nxt.psr = 1'b0;
		end

		wr_ok = 1'b1;
		if (wr_fire) begin
			case (widx)
				IDX_FLAGS: begin
					if (axil_req.wstrb[0]) begin
						clr_v = clr_v | axil_req.wdata[7:0];
					end
				end
				IDX_MASK: begin
					if (axil_req.wstrb[0]) begin
						st_nxt.mask = axil_req.wdata[7:0] & FLAG_MASK;
					end
				end
				IDX_CTRL: begin
					if (axil_req.wstrb[0]) begin
						st_nxt.ctrl[7:0] = axil_req.wdata[7:0];
					end
					if (axil_req.wstrb[1]) begin
						st_nxt.ctrl[10:8] = axil_req.wdata[10:8];
					end
				end
				IDX_SYNC: begin
					if (axil_req.wstrb[0]) begin
						st_nxt.sync_hold = axil_req.wdata[BIT_SYNC_HOLD];
						st_nxt.psr = axil_req.wdata[BIT_PSR];
					end
				end
				IDX_CMP_A: begin
					if (axil_req.wstrb[0]) begin
						st_nxt.cmp_a[7:0] = axil_req.wdata[7:0];
					end
					if (axil_req.wstrb[1]) begin
						st_nxt.cmp_a[15:8] = axil_req.wdata[15:8];
					end
				end
				IDX_CMP_B: begin
					if (axil_req.wstrb[0]) begin
						st_nxt.cmp_b[7:0] = axil_req.wdata[7:0];
					end
					if (axil_req.wstrb[1]) begin
						st_nxt.cmp_b[15:8] = axil_req.wdata[15:8];
					end
				end
				default: wr_ok = 1'b0;
			endcase
			st_nxt.rsp.bvalid = 1'b1;
			st_nxt.rsp.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end

		// set after clear so a coincident event survives
		flags_n = ((st_r.flags & ~clr_v) | set_v) & FLAG_MASK;
		st_nxt.flags = flags_n;

		rd_ok = 1'b1;
		rd_val = '0;
		case (ridx)
			IDX_FLAGS: rd_val[7:0] = st_r.flags & FLAG_MASK;
			IDX_MASK: rd_val[7:0] = st_r.mask & FLAG_MASK;
			IDX_CTRL: rd_val[10:0] = st_r.ctrl;
			IDX_SYNC: begin
				rd_val[BIT_SYNC_HOLD] = st_r.sync_hold;
				rd_val[BIT_PSR] = st_r.psr;
			end
			IDX_CMP_A: rd_val[15:0] = st_r.cmp_a;
			IDX_CMP_B: rd_val[15:0] = st_r.cmp_b;
			default: rd_ok = 1'b0;
		endcase
		if (rd_fire) begin
			st_nxt.rsp.rvalid = 1'b1;
			st_nxt.rsp.rdata = rd_val;
			st_nxt.rsp.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end

		////////////////////////////////////////////////////////////////////
		// request lines are registered from the next flags and mask, so they change in the same cycle as the flags
		st_nxt.irq[3] = st_nxt.mask[BIT_CAP] & global_irq_en & flags_n[BIT_CAP];
		st_nxt.irq[2] = st_nxt.mask[BIT_CMP_B] & global_irq_en & flags_n[BIT_CMP_B];
		st_nxt.irq[1] = st_nxt.mask[BIT_CMP_A] & global_irq_en & flags_n[BIT_CMP_A];
		st_nxt.irq[0] = st_nxt.mask[BIT_OVF] & global_irq_en & flags_n[BIT_OVF];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
			st_r.flags <= FLAGS_RST;
			st_r.mask <= MASK_RST;
			st_r.ctrl <= CTRL_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign axil_rsp = st_r.rsp;
	assign timer_tick = st_r.tick;
	assign irq_req = st_r.irq;
	assign waveform_mode = st_r.ctrl[WGM_LSB +: 4];
	assign compare_a_reg = st_r.cmp_a;
	assign compare_b_reg = st_r.cmp_b;
endmodule : timer_irq_flags_and_prescaler

////////////////////////////////////////////////////////////////////////
// two flops, then an edge stage; only the second flop reads the first
module pin_edge_sync #(
	parameter int W = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] pin,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
	} sync_t;

	sync_t sy_r;
	sync_t sy_nxt;

	// the transparent latch of the sampling path is modelled as a plain flop
	always_comb begin
		sy_nxt = sy_r;
		sy_nxt.s1 = pin;
		sy_nxt.s2 = sy_r.s1;
		sy_nxt.s3 = sy_r.s2;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sy_r <= '0;
		end else begin
			sy_r <= sy_nxt;
		end
	end

	// resets low like an idle pin, so no false edge follows reset
	assign rise = sy_r.s2 & ~sy_r.s3;
	assign fall = ~sy_r.s2 & sy_r.s3;
endmodule : pin_edge_sync

////////////////////////////////////////////////////////////////////////
// clock source of one timer; pin edges go around the prescaler
module tick_select #(
	parameter int PW = timer_irq_pkg::PRE_W
) (
	input wire logic [2:0] sel,
	input wire logic [PW-1:0] pre_cnt,
	input wire logic psr,
	input wire logic rise,
	input wire logic fall,
	output logic tick
);
	import timer_irq_pkg::*;

	// a tap fires when its low count bits are all ones; the phase is
	// whatever the free-running count holds, hence the 1 to N latency
	// the prescaler reset masks only the taps, not the undivided or pin ticks
	always_comb begin
		case (sel)
			3'h1: tick = 1'b1;
			3'h2: tick = (&pre_cnt[TAP8_W-1:0]) & ~psr;
			3'h3: tick = (&pre_cnt[TAP64_W-1:0]) & ~psr;
			3'h4: tick = (&pre_cnt[TAP256_W-1:0]) & ~psr;
			3'h5: tick = (&pre_cnt[TAP1024_W-1:0]) & ~psr;
			3'h6: tick = fall;
			3'h7: tick = rise;
			default: tick = 1'b0;
		endcase
	end
endmodule : tick_select
`default_nettype wire

//--- bench/timer_irq_checker.sv
`timescale 1ns/1ps
`default_nettype none
module timer_irq_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire timer_irq_pkg::axil_req_t axil_req,
	input wire timer_irq_pkg::axil_rsp_t axil_rsp,
	input wire logic global_irq_en,
	input wire logic [3:0] vector_ack,
	input wire logic [1:0] timer_tick,
	input wire logic [3:0] irq_req
);
	import timer_irq_pkg::*;
	logic [7:0] ra_r;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// read address kept so read data can be judged per register
	always_ff @(posedge aclk)
		if (axil_req.arvalid && axil_rsp.arready) ra_r <= axil_req.araddr;
	////////////////////////////////////////
	a_irq_gated: assert property (!global_irq_en && $past(!global_irq_en) |-> irq_req == 4'h0)
		else $error("irq with global enable off");
	// compare flags only set on a tick, so an ack without one must clear
	a_ack_clear: assert property (vector_ack[1] && !timer_tick[1] |=> !irq_req[1])
		else $error("ack did not clear compare irq");
	a_rsv_zero: assert property (axil_rsp.rvalid && ra_r inside {8'h2c, 8'h30} |-> axil_rsp.rdata[7:6] == 2'h0 && axil_rsp.rdata[4:3] == 2'h0)
		else $error("reserved bits read nonzero");
	a_b_done: assert property (axil_rsp.bvalid && axil_req.bready |=> !axil_rsp.bvalid)
		else $error("bvalid stuck");
	a_r_done: assert property (axil_rsp.rvalid && axil_req.rready |=> !axil_rsp.rvalid)
		else $error("rvalid stuck");
	a_rdy_pair: assert property (axil_rsp.awready == axil_rsp.wready)
		else $error("awready wready apart");
	a_ar_pulse: assert property (axil_rsp.arready |=> !axil_rsp.arready)
		else $error("arready too long");
	a_aw_resp: assert property (axil_rsp.awready && axil_req.awvalid |=> axil_rsp.bvalid)
		else $error("no write response");
	cover property (irq_req[1]);
	cover property ($rose(timer_tick[0]));
	cover property (axil_rsp.rvalid && axil_rsp.rresp == RESP_SLVERR);
endmodule : timer_irq_checker
bind timer_irq_flags_and_prescaler timer_irq_checker timer_irq_checker_inst (.aclk, .aresetn,
	.axil_req, .axil_rsp, .global_irq_en, .vector_ack, .timer_tick, .irq_req);
`default_nettype wire

//--- bench/count_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module count_pin_model (
	input wire logic aclk,
	input wire logic run,
	input wire logic [3:0] half,
	output logic pin,
	output int rises,
	output int falls
);
	int cnt = 0;
	initial pin = 1'b0;
	initial rises = 0;
	initial falls = 0;
	// half kept at two clocks or more so no level slips between samples
	// pin frozen unless run, so selects change on a stable pin
	always @(posedge aclk)
		if (run) begin
			cnt <= (cnt + 1 >= half) ? 0 : cnt + 1;
			if (cnt + 1 >= half) begin
				pin <= !pin;
				if (pin) falls <= falls + 1;
				else rises <= rises + 1;
			end
		end
endmodule : count_pin_model
`default_nettype wire

//--- bench/test_timer_irq_flags_and_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module test_timer_irq_flags_and_prescaler;
	import timer_irq_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	axil_req_t req = '0;
	axil_rsp_t rsp;
	core_evt_t ev = '0;
	logic gie = 1'b0;
	logic [3:0] ack = 4'h0;
	logic cap = 1'b0;
	logic run = 1'b0;
	logic [3:0] half = 4'h2;
	logic pin;
	logic [1:0] tick;
	logic [3:0] irq;
	logic [3:0] wmode;
	logic [31:0] d;
	logic [1:0] r;
	logic [15:0] v;
	logic [15:0] ca;
	logic [15:0] cb;
	int rises, falls, n0, n1, e, cyc = 0, num_errors = 0, num_checks = 0, seed = 87595;
	timer_irq_flags_and_prescaler timer_irq_flags_and_prescaler_inst (.aclk, .aresetn,
		.axil_req(req), .axil_rsp(rsp), .core_evt(ev), .global_irq_en(gie), .vector_ack(ack),
		.capture_input_pin(cap), .ext_count_pin({pin, pin}), .timer_tick(tick), .irq_req(irq),
		.waveform_mode(wmode), .compare_a_reg(ca), .compare_b_reg(cb));
	count_pin_model count_pin_model_inst (.aclk, .run, .half, .pin, .rises, .falls);
	always #2.5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			end_sim();
		end
	end
	////////////////////////////////////////
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		num_checks++;
		if (s !== x) begin
			num_errors++;
			$display("BAD t=%0t seen %h exp %h", $time, s, x);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] dat);
		req.awaddr <= a;
		req.wdata <= dat;
		req.wstrb <= 4'hf;
		{req.awvalid, req.wvalid, req.bready} <= 3'b111;
		do @(posedge aclk); while (rsp.awready !== 1'b1);
		{req.awvalid, req.wvalid} <= 2'b00;
		do @(posedge aclk); while (rsp.bvalid !== 1'b1);
		req.bready <= 1'b0;
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		req.araddr <= a;
		{req.arvalid, req.rready} <= 2'b11;
		do @(posedge aclk); while (rsp.arready !== 1'b1);
		req.arvalid <= 1'b0;
		do @(posedge aclk); while (rsp.rvalid !== 1'b1);
		d = rsp.rdata;
		r = rsp.rresp;
		req.rready <= 1'b0;
		@(posedge aclk);
	endtask : rd
	// stops the pin 8 clocks early so the sync pipeline drains inside the window
	task automatic count(input int w);
		n0 = 0;
		n1 = 0;
		for (int i = 0; i < w; i++) begin
			@(posedge aclk);
			n0 += tick[0];
			n1 += tick[1];
			if (i == w - 8) run <= 1'b0;
		end
	endtask : count
	function automatic int div(input int s);
		int t[6] = '{0, 1, 8, 64, 256, 1024};
		return t[s];
	endfunction : div
	function automatic int ovf_src(input int m);
		if (m inside {0, 4, 12}) return 0;
		if (m inside {5, 6, 7, 14, 15}) return 2;
		return (m == 13) ? 3 : 1;
	endfunction : ovf_src
	////////////////////////////////////////
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(8'h2c);
		chk(d, 32'h0);
		wr(8'h30, 32'hff);
		rd(8'h30);
		chk(d, 32'h27);
		rd(8'h3c);
		chk(r, RESP_SLVERR);
		$display("registers done");
		for (int s = 1; s <= 5; s++) begin
			wr(8'h34, 32'(s | 8));
			count(2048);
			chk(n1, 2048 / div(s));
			chk(n0, 2048);
		end
		wr(8'h38, 32'h81);
		wr(8'h34, 32'h2);
		count(64);
		chk(n1, 0);
		rd(8'h38);
		chk(d, 32'h81);
		wr(8'h38, 32'h0);
		count(9);
		chk(n1 != 0, 1);
		wr(8'h38, 32'h1);
		rd(8'h38);
		chk(d, 32'h0);
		wr(8'h34, 32'h37);
		half <= 4'(2 + $unsigned($random(seed)) % 4);
		run <= 1'b1;
		count(400);
		chk(n1, rises);
		chk(n0, falls);
		$display("prescaler done");
		for (int m = 0; m < 16; m++) begin
			e = $unsigned($random(seed)) % 3;
			wr(8'h34, 32'(m << 6));
			chk(wmode, m[3:0]);
			{ev.at_top, ev.at_bottom, ev.at_max} <= 3'(1 << e);
			@(posedge aclk);
			{ev.at_top, ev.at_bottom, ev.at_max} <= 3'h0;
			rd(8'h2c);
			chk(d[0], ovf_src(m) == e);
			chk(d[5], e == 2 && m inside {8, 10, 12, 14});
			wr(8'h2c, 32'h21);
		end
		v = 16'($random(seed));
		ev.count_value <= v;
		wr(8'h40, 32'(v));
		wr(8'h44, 32'(v + 16'h1));
		chk(ca, v);
		chk(cb, 16'(v + 16'h1));
		wr(8'h34, 32'h1);
		// zero matches left pending by earlier phases are dropped here;
		// compare A matches on every tick, so its set beats the clear
		wr(8'h2c, 32'h27);
		rd(8'h2c);
		chk(d, 32'h2);
		gie <= 1'b1;
		repeat (4) @(posedge aclk);
		chk(irq, 4'h2);
		wr(8'h34, 32'h0);
		ack <= 4'h2;
		@(posedge aclk);
		ack <= 4'h0;
		@(posedge aclk);
		chk(irq, 4'h0);
		gie <= 1'b0;
		wr(8'h34, 32'h400);
		cap <= 1'b1;
		repeat (6) @(posedge aclk);
		chk(irq, 4'h0);
		rd(8'h2c);
		chk(d, 32'h20);
		gie <= 1'b1;
		repeat (3) @(posedge aclk);
		chk(irq, 4'h8);
		wr(8'h2c, 32'h20);
		chk(irq, 4'h0);
		$display("flags done");
		end_sim();
	end
endmodule : test_timer_irq_flags_and_prescaler
`default_nettype wire
